// ==== osc_pkg.sv ====
// Purpose: shared constants for the internal oscillator clock switch
// Assumes: one 25 MHz system clock; oscillators modelled as enable pulses
// Notes:   frequency codes, reset values and timing counts live here
package osc_pkg;

  // ************************************************************
  // frequency select codes
  // ************************************************************
  localparam logic [2:0] FSEL_31K   = 3'h0;
  localparam logic [2:0] FSEL_125K  = 3'h1;
  localparam logic [2:0] FSEL_4M    = 3'h6;
  localparam logic [2:0] FSEL_8M    = 3'h7;
  localparam logic [2:0] FSEL_RESET = FSEL_4M;

  // ************************************************************
  // timing
  // ************************************************************
  localparam int SYS_CLK_HZ     = 25000000;
  localparam int HF_OSC_HZ      = 8000000;
  localparam int LF_OSC_HZ      = 31000;
  // half periods in system cycles, rounded down, at least one
  localparam int HF_HALF_CYC    = SYS_CLK_HZ / (2 * HF_OSC_HZ);
  localparam int LF_HALF_CYC    = SYS_CLK_HZ / (2 * LF_OSC_HZ);
  localparam int OST_CYCLES     = 1024;
  // start-up delays in oscillator half periods
  localparam int HF_START_HALFS = 16;
  localparam int LF_START_HALFS = 4;
  localparam int CNT_W          = 16;

  typedef enum logic [1:0] {
    SRC_INT,
    SRC_EXT
  } sys_src_t;

endpackage : osc_pkg

// ==== osc_src_if.sv ====
// Purpose: carrier between oscillator models and the switch logic
// Assumes: one clock domain
// Notes:   each oscillator reports its level, its edges and stability
`timescale 1ns/1ps
interface osc_src_if;
  logic run;      // request the oscillator to run
  logic level;    // current oscillator output level
  logic rise;     // one-cycle pulse on rising edge
  logic fall;     // one-cycle pulse on falling edge
  logic stable;   // start-up delay is over

  modport osc (input run, output level, rise, fall, stable);
  modport user (output run, input level, rise, fall, stable);
endinterface : osc_src_if

// ==== int_osc.sv ====
// Purpose: internal oscillator model driven from the system clock
// Assumes: the oscillator is an ideal divider of sys_clk
// Notes:   stable rises after START_HALFS half periods of running
`timescale 1ns/1ps
module int_osc
  import osc_pkg::*;
#(
  parameter int HALF_CYC    = 1,   // system cycles per half period
  parameter int START_HALFS = 4    // half periods before stable
) (
  input  wire logic sys_clk,       // system clock
  input  wire logic rst_n,         // synchronous reset, active low
  osc_src_if.osc    o              // oscillator side
);

  logic [CNT_W-1:0] div_r;
  logic [CNT_W-1:0] start_r;
  logic             lvl_r;
  logic             tick;

  assign tick = o.run && (div_r == CNT_W'(HALF_CYC - 1));

  always_ff @(posedge sys_clk) begin
    if (!rst_n || !o.run || tick) begin
      div_r <= '0;
    end else begin
      div_r <= div_r + 1'b1;
    end
  end

  // a stopped oscillator parks low
  always_ff @(posedge sys_clk) begin
    if (!rst_n || !o.run) begin
      lvl_r <= 1'b0;
    end else if (tick) begin
      lvl_r <= ~lvl_r;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n || !o.run) begin
      start_r <= '0;
    end else if (tick && start_r != CNT_W'(START_HALFS)) begin
      start_r <= start_r + 1'b1;
    end
  end

  assign o.level  = lvl_r;
  assign o.rise   = tick && !lvl_r;
  assign o.fall   = tick && lvl_r;
  assign o.stable = (start_r == CNT_W'(START_HALFS));

endmodule : int_osc

// ==== clk_switch.sv ====
// Purpose: internal clock selection, glitch-free switching, two-speed
//          start-up to an external crystal clock
// Assumes: inputs synchronous to sys_clk; ext_clk_in sampled as a level
// Notes:   the clock output is a register toggled from oscillator edges, or copying the sampled external level
`timescale 1ns/1ps
module clk_switch
  import osc_pkg::*;
(
  input  wire logic       sys_clk,            // system clock, 25 MHz
  input  wire logic       rst_n,              // sync reset, active low
  input  wire logic       wake_start,         // power-on or wake pulse
  input  wire logic [2:0] freq_sel_wr_data,   // new frequency select
  input  wire logic       freq_sel_wr,        // write strobe for select
  input  wire logic       system_clock_select,// 1: internal clock
  input  wire logic       two_speed_startup_enable, // two-speed on
  input  wire logic       ext_crystal_cfg,    // external crystal mode
  input  wire logic       power_up_timer_en,  // power-up timer on
  input  wire logic       watchdog_timer_en,  // watchdog on
  input  wire logic       fail_safe_clock_monitor_en, // monitor on
  input  wire logic       ext_clk_in,         // external clock level
  output logic            clock_output_pin,   // switched clock out
  output logic [2:0]      internal_freq_select, // select readback
  output logic            low_freq_stable,    // low osc stable status
  output logic            high_freq_stable,   // high osc stable status
  output logic            external_clock_running, // on external clock
  output logic            low_freq_timebase,  // 31 kHz timer clock
  output logic            switch_busy         // switch in progress
);

  // ************************************************************
  // oscillators
  // ************************************************************
  osc_src_if hf_if ();
  osc_src_if lf_if ();

  int_osc #(
    .HALF_CYC    (HF_HALF_CYC),
    .START_HALFS (HF_START_HALFS)
  ) u_hf (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .o       (hf_if)
  );

  int_osc #(
    .HALF_CYC    (LF_HALF_CYC),
    .START_HALFS (LF_START_HALFS)
  ) u_lf (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .o       (lf_if)
  );

  // ************************************************************
  // state
  // ************************************************************
  typedef enum logic [2:0] {
    ST_RUN,
    ST_START_WAIT,
    ST_OLD_FALL,
    ST_NEW_RISE,
    ST_EXT_FALL
  } sw_state_t;

  sw_state_t        st_r;
  logic [2:0]       sel_r;       // requested select
  logic [2:0]       cur_r;       // select now connected
  logic [5:0]       div_r;       // postscaler counter
  logic             clk_r;
  logic             lts_r;
  logic             hts_r;
  logic             ext_run_r;
  logic             ext_q_r;
  logic             ts_active_r;
  logic             ost_done_r;
  logic [10:0]      ost_cnt_r;
  sys_src_t         src_r;
  logic             busy_r;
  logic             lf_tb_r;

  function automatic logic is_lf(input logic [2:0] code);
    return code == FSEL_31K;
  endfunction : is_lf

  // postscaler ratio: 111 is /1, 110 /2 ... 001 /64
  function automatic logic [2:0] post_shift(input logic [2:0] code);
    return 3'h7 - code;
  endfunction : post_shift

  // ************************************************************
  // oscillator enables
  // ************************************************************
  logic lf_need;
  logic hf_need;

  assign lf_need = (is_lf(sel_r) && system_clock_select)
                 || (two_speed_startup_enable && is_lf(sel_r))
                 || is_lf(cur_r)
                 || power_up_timer_en || watchdog_timer_en
                 || fail_safe_clock_monitor_en;
  // high oscillator kept only while a postscaled code is used
  assign hf_need = !is_lf(sel_r) || !is_lf(cur_r);

  assign lf_if.run = lf_need;
  assign hf_if.run = hf_need;

  // postscaled internal clock edges
  logic [2:0] shift_c;
  logic       post_edge;
  logic       new_edge_r;   // rising edge of the requested clock
  logic       cur_fall;
  logic       new_rise;

  assign shift_c   = post_shift(cur_r);
  assign post_edge = hf_if.rise || hf_if.fall;

  // postscaler toggles on 2^shift oscillator half periods
  // cleared while the oscillator is stopped: a restart must keep even
  // counts on rising edges, or a postscaled new-rise never comes
  always_ff @(posedge sys_clk) begin
    if (!rst_n || !hf_if.run) begin
      div_r <= 6'h00;
    end else if (post_edge) begin
      div_r <= div_r + 6'h01;
    end
  end

  function automatic logic pscale_edge(input logic [2:0] sh,
                                        input logic [5:0] cnt);
    logic [6:0] mask;
    mask = 7'((7'h01 << sh) - 7'h01);
    return ({1'b0, cnt} & mask) == 7'h00;
  endfunction : pscale_edge

  // ************************************************************
  // clock output
  // ************************************************************
  logic int_toggle;
  assign int_toggle = is_lf(cur_r) ? (lf_if.rise || lf_if.fall)
                    : (post_edge && pscale_edge(shift_c, div_r));
  assign cur_fall   = int_toggle && clk_r;
  assign new_rise   = is_lf(sel_r) ? lf_if.rise
                    : (hf_if.rise && pscale_edge(post_shift(sel_r), div_r));

  // glitch-free output: low while waiting for the new clock
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      clk_r <= 1'b0;
    end else if (src_r == SRC_EXT) begin
      clk_r <= ext_in_lvl();
    end else begin
      case (st_r)
        ST_RUN, ST_START_WAIT, ST_OLD_FALL: begin
          if (int_toggle) clk_r <= ~clk_r;
        end
        ST_NEW_RISE: clk_r <= new_rise;
        ST_EXT_FALL: clk_r <= 1'b0;
        default:     clk_r <= 1'b0;
      endcase
    end
  end

  function automatic logic ext_in_lvl();
    return ext_q_r;
  endfunction : ext_in_lvl

  // ************************************************************
  // switch sequencer
  // ************************************************************
  logic target_stable;
  assign target_stable = is_lf(sel_r) ? lf_if.stable : hf_if.stable;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      sel_r <= FSEL_RESET;
    end else if (freq_sel_wr) begin
      sel_r <= freq_sel_wr_data;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      st_r  <= ST_RUN;
      cur_r <= FSEL_RESET;
      lts_r <= 1'b0;
      hts_r <= 1'b0;
    end else begin
      case (st_r)
        ST_RUN: begin
          if (sel_r != cur_r) begin
            // switches between two postscaled codes skip the start-up wait
            if (!is_lf(sel_r) && !is_lf(cur_r)) st_r <= ST_OLD_FALL;
            else st_r <= ST_START_WAIT;
          end else begin
            lts_r <= lf_if.stable && is_lf(cur_r);
            hts_r <= hf_if.stable && !is_lf(cur_r);
          end
        end
        // start target and wait out its delay
        ST_START_WAIT: if (target_stable) st_r <= ST_OLD_FALL;
        ST_OLD_FALL: if (cur_fall) st_r <= ST_NEW_RISE;
        ST_NEW_RISE: begin
          if (new_rise) begin
            cur_r <= sel_r;
            lts_r <= is_lf(sel_r) && lf_if.stable;
            hts_r <= !is_lf(sel_r) && hf_if.stable;
            st_r  <= ST_RUN;
          end
        end
        default: st_r <= ST_RUN;
      endcase
    end
  end

  // ************************************************************
  // two-speed start-up
  // ************************************************************
  logic ext_fall;
  always_ff @(posedge sys_clk) begin
    if (!rst_n) ext_q_r <= 1'b0;
    else        ext_q_r <= ext_clk_in;
  end
  assign ext_fall = ext_q_r && !ext_clk_in;

  // start on the internal clock after wake
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      ts_active_r <= 1'b0;
    end else if (wake_start && two_speed_startup_enable
                 && ext_crystal_cfg) begin
      ts_active_r <= 1'b1;
    end else if (src_r == SRC_EXT) begin
      ts_active_r <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n || wake_start) begin
      ost_cnt_r  <= '0;
      ost_done_r <= 1'b0;
    end else if (ts_active_r && !ext_q_r && ext_clk_in && !ost_done_r) begin
      ost_cnt_r <= ost_cnt_r + 11'h001;
      if (ost_cnt_r == 11'(OST_CYCLES - 1)) ost_done_r <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n || wake_start) begin
      ext_run_r <= 1'b0;
      src_r     <= SRC_INT;
    end else if (ts_active_r && ost_done_r) begin
      if (!ext_run_r && cur_fall) ext_run_r <= 1'b1;
      if (ext_run_r && ext_fall) src_r <= SRC_EXT;
    end
  end

  // ************************************************************
  // status and time base
  // ************************************************************
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      busy_r  <= 1'b0;
      lf_tb_r <= 1'b0;
    end else begin
      busy_r  <= (st_r != ST_RUN) || (sel_r != cur_r);
      lf_tb_r <= lf_if.level;
    end
  end

  assign low_freq_stable        = lts_r;
  assign high_freq_stable       = hts_r;
  assign external_clock_running = ext_run_r;
  assign clock_output_pin       = clk_r;
  assign internal_freq_select   = sel_r;
  assign low_freq_timebase      = lf_tb_r;
  assign switch_busy            = busy_r;

endmodule : clk_switch

// ==== clk_switch_asserts.sv ====
// Purpose: concurrent checks on the clock switch top-level ports
// Assumes: one clock domain, synchronous active-low reset
// Notes:   long waits are tracked by saturating helper counters
`timescale 1ns/1ps
module clk_switch_asserts
  import osc_pkg::*;
(
  input wire logic       sys_clk,                  // system clock
  input wire logic       rst_n,                    // sync reset
  input wire logic       wake_start,               // start pulse
  input wire logic [2:0] freq_sel_wr_data,         // select data
  input wire logic       freq_sel_wr,              // select strobe
  input wire logic       two_speed_startup_enable, // two-speed on
  input wire logic       ext_crystal_cfg,          // crystal mode
  input wire logic       power_up_timer_en,        // timer on
  input wire logic       watchdog_timer_en,        // watchdog on
  input wire logic       fail_safe_clock_monitor_en, // monitor on
  input wire logic [2:0] internal_freq_select,     // readback
  input wire logic       external_clock_running,   // ext status
  input wire logic       low_freq_timebase,        // 31 kHz level
  input wire logic       switch_busy               // switch pending
);
  // ************************************************************
  // helper counters
  // ************************************************************
  localparam int BUSY_MAX = 6000;
  localparam int LF_GAP   = 2 * LF_HALF_CYC;
  localparam int OST_MIN  = 2 * OST_CYCLES;
  logic [15:0] busy_r;
  logic [15:0] wake_r;
  logic [15:0] lf_gap_r;
  logic        tmr_on;
  assign tmr_on = power_up_timer_en | watchdog_timer_en |
                  fail_safe_clock_monitor_en;
  always_ff @(posedge sys_clk) begin
    if (!rst_n || !switch_busy) busy_r <= 16'h0000;
    else if (busy_r != 16'hFFFF) busy_r <= busy_r + 16'h0001;
  end
  // external clock needs two sys cycles per rising edge at least
  always_ff @(posedge sys_clk) begin
    if (!rst_n || wake_start) wake_r <= 16'h0000;
    else if (wake_r != 16'hFFFF) wake_r <= wake_r + 16'h0001;
  end
  always_ff @(posedge sys_clk) begin
    if (!rst_n || !tmr_on || $changed(low_freq_timebase))
      lf_gap_r <= 16'h0000;
    else if (lf_gap_r != 16'hFFFF) lf_gap_r <= lf_gap_r + 16'h0001;
  end
  // ************************************************************
  // assertions
  // ************************************************************
  a_reset_select: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    $rose(rst_n) |-> internal_freq_select == FSEL_RESET)
    else $error("select not at reset code after reset");
  a_write_readback: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    freq_sel_wr |=> internal_freq_select == $past(freq_sel_wr_data))
    else $error("select readback differs from written code");
  a_select_holds: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    !freq_sel_wr |=> $stable(internal_freq_select))
    else $error("select changed without a write");
  // busy is registered from the select, itself one cycle after the strobe
  a_write_busy: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    freq_sel_wr && freq_sel_wr_data != internal_freq_select
      |-> ##2 switch_busy)
    else $error("switch not pending after a new code");
  a_switch_bounded: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    busy_r < BUSY_MAX)
    else $error("clock switch did not complete in time");
  a_ext_config: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    $rose(external_clock_running) |->
      two_speed_startup_enable && ext_crystal_cfg)
    else $error("external clock taken without two-speed crystal");
  a_ost_count: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    $rose(external_clock_running) |-> wake_r >= OST_MIN)
    else $error("external clock taken before start-up count");
  a_timer_base: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    lf_gap_r <= LF_GAP)
    else $error("low time base idle while a timer is enabled");
endmodule : clk_switch_asserts

bind clk_switch clk_switch_asserts u_asserts (
  .sys_clk                    (sys_clk),
  .rst_n                      (rst_n),
  .wake_start                 (wake_start),
  .freq_sel_wr_data           (freq_sel_wr_data),
  .freq_sel_wr                (freq_sel_wr),
  .two_speed_startup_enable   (two_speed_startup_enable),
  .ext_crystal_cfg            (ext_crystal_cfg),
  .power_up_timer_en          (power_up_timer_en),
  .watchdog_timer_en          (watchdog_timer_en),
  .fail_safe_clock_monitor_en (fail_safe_clock_monitor_en),
  .internal_freq_select       (internal_freq_select),
  .external_clock_running     (external_clock_running),
  .low_freq_timebase          (low_freq_timebase),
  .switch_busy                (switch_busy)
);

// ==== internal_osc_clock_switch_test.sv ====
// Purpose: directed bench for the internal oscillator clock switch
// Assumes: inputs change on the falling edge of sys_clk
// Notes:   external crystal is a bench divider, period 4 system cycles
`timescale 1ns/1ps
module internal_osc_clock_switch_test;
  import osc_pkg::*;
  logic sys_clk = 1'b0, rst_n = 1'b0, wake_start = 1'b0;
  logic [2:0] freq_sel_wr_data = 3'h0;
  logic freq_sel_wr = 1'b0, system_clock_select = 1'b1;
  logic two_speed_startup_enable = 1'b0, ext_crystal_cfg = 1'b0;
  logic power_up_timer_en = 1'b0, watchdog_timer_en = 1'b0;
  logic fail_safe_clock_monitor_en = 1'b0, ext_clk_in = 1'b0;
  logic ext_run = 1'b0, ext_div = 1'b0;
  logic clock_output_pin, low_freq_stable, high_freq_stable;
  logic external_clock_running, low_freq_timebase, switch_busy;
  logic [2:0] internal_freq_select;
  int fails = 0, samples_checked = 0;
  clk_switch u_dut (.sys_clk(sys_clk), .rst_n(rst_n),
    .wake_start(wake_start), .freq_sel_wr_data(freq_sel_wr_data),
    .freq_sel_wr(freq_sel_wr), .system_clock_select(system_clock_select),
    .two_speed_startup_enable(two_speed_startup_enable),
    .ext_crystal_cfg(ext_crystal_cfg),
    .power_up_timer_en(power_up_timer_en),
    .watchdog_timer_en(watchdog_timer_en),
    .fail_safe_clock_monitor_en(fail_safe_clock_monitor_en),
    .ext_clk_in(ext_clk_in), .clock_output_pin(clock_output_pin),
    .internal_freq_select(internal_freq_select),
    .low_freq_stable(low_freq_stable), .high_freq_stable(high_freq_stable),
    .external_clock_running(external_clock_running),
    .low_freq_timebase(low_freq_timebase), .switch_busy(switch_busy));
  // ************************************************************
  // clock, external crystal, watchdog
  // ************************************************************
  initial forever #20 sys_clk = ~sys_clk;
  always @(negedge sys_clk) begin
    if (ext_run) begin
      ext_div <= ~ext_div;
      if (ext_div) ext_clk_in <= ~ext_clk_in;
    end
  end
  initial begin
    // the scenarios need about 11k cycles; this allows 50k
    #2000000;
    fails = fails + 1;
    finish_test();
  end
  // ************************************************************
  // shared tasks
  // ************************************************************
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    samples_checked = samples_checked + 1;
    if (got !== exp) begin
      fails = fails + 1;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task automatic wait_idle(input int lim, output int used);
    used = 0;
    while (switch_busy !== 1'b0 && used < lim) begin
      @(negedge sys_clk);
      used = used + 1;
    end
  endtask : wait_idle
  task automatic write_sel(input logic [2:0] code);
    freq_sel_wr_data = code;
    freq_sel_wr = 1'b1;
    @(negedge sys_clk);
    freq_sel_wr = 1'b0;
    @(negedge sys_clk);
  endtask : write_sel
  task automatic count_edges(input logic sel, input int n, output int c);
    logic last;
    c = 0;
    last = sel ? low_freq_timebase : clock_output_pin;
    repeat (n) begin
      @(negedge sys_clk);
      if ((sel ? low_freq_timebase : clock_output_pin) !== last) c++;
      last = sel ? low_freq_timebase : clock_output_pin;
    end
  endtask : count_edges
  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic t_reset();
    check(internal_freq_select, FSEL_RESET);
    check(external_clock_running, 1'b0);
    // the high oscillator reads stable only after its start-up halves
    repeat (20) @(negedge sys_clk);
    check(high_freq_stable, 1'b1);
    check(low_freq_stable, 1'b0);
  endtask : t_reset
  task automatic t_codes();
    logic [2:0] codes [8] = '{3'h7, 3'h5, 3'h4, 3'h3, 3'h2, 3'h1,
                              3'h0, 3'h6};
    int used;
    foreach (codes[i]) begin
      write_sel(codes[i]);
      check(internal_freq_select, codes[i]);
      wait_idle(8000, used);
      check(switch_busy, 1'b0);
      if (codes[i] == FSEL_31K) check(low_freq_stable, 1'b1);
      else check(high_freq_stable, 1'b1);
      check(low_freq_stable & high_freq_stable, 1'b0);
    end
  endtask : t_codes
  task automatic t_fast();
    int used;
    write_sel(FSEL_8M);
    wait_idle(8000, used);
    // postscaler codes share one running oscillator
    check(used < 64, 1'b1);
    write_sel(FSEL_125K);
    wait_idle(8000, used);
    check(used < 400, 1'b1);
    write_sel(FSEL_RESET);
    wait_idle(8000, used);
  endtask : t_fast
  task automatic t_timebase();
    int c;
    for (int k = 0; k < 3; k++) begin
      power_up_timer_en = (k == 0);
      watchdog_timer_en = (k == 1);
      fail_safe_clock_monitor_en = (k == 2);
      count_edges(1'b1, 1000, c);
      // 1000 cycles see at most three 31 kHz edges, 403 cycles apart
      check(c >= 1 && c <= 3, 1'b1);
    end
    fail_safe_clock_monitor_en = 1'b0;
  endtask : t_timebase
  task automatic t_two_speed();
    int c;
    two_speed_startup_enable = 1'b1;
    ext_crystal_cfg = 1'b1;
    ext_run = 1'b1;
    wake_start = 1'b1;
    @(negedge sys_clk);
    wake_start = 1'b0;
    count_edges(1'b0, 200, c);
    check(c > 0, 1'b1);
    repeat (3800) @(negedge sys_clk);
    check(external_clock_running, 1'b0);
    c = 0;
    while (external_clock_running !== 1'b1 && c < 3000) begin
      @(negedge sys_clk);
      c++;
    end
    check(external_clock_running, 1'b1);
    repeat (20) @(negedge sys_clk);
    count_edges(1'b0, 40, c);
    check(c > 0, 1'b1);
    // the internal clock toggles at the same rate, so freeze the crystal:
    // an output that is really switched must stop with it
    ext_run = 1'b0;
    repeat (4) @(negedge sys_clk);
    count_edges(1'b0, 40, c);
    check(c, 16'h0000);
  endtask : t_two_speed
  task automatic finish_test();
    $display("checks=%0d fails=%0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : finish_test
  initial begin
    repeat (2) @(negedge sys_clk);
    rst_n = 1'b1;
    @(negedge sys_clk);
    t_reset();
    t_codes();
    t_fast();
    t_timebase();
    t_two_speed();
    finish_test();
  end
endmodule : internal_osc_clock_switch_test
